/* fbio_pkg.sv */
// Package: register map, field positions and reset values of the I/O port
package fbio_pkg;
  localparam int ADDR_W = 12;
  localparam logic [11:0] OFF_PORT_DATA = 12'hf60;
  localparam logic [11:0] OFF_PORT_DIRECTION = 12'hf7d;
  localparam logic [11:0] OFF_PORT_PULLUP_CONTROL = 12'hf7e;
  localparam int PORT_W = 4;
  localparam int DIR_BIT = 0;
  localparam int PUP_BIT = 0;
  localparam logic RST_DIRECTION = 1'b0;
  localparam logic RST_PULLUP_DISABLE = 1'b0;
  localparam logic [3:0] RST_PORT_DATA = 4'h0;
endpackage

/* fbio_pin_if.sv */
// Interface: pin-side signals between the port core and the pin stage
`timescale 1ns/1ps
interface fbio_pin_if;
  logic [3:0] pin_sync;
  logic [3:0] pin_raw;
  modport core (input pin_sync);
  modport pins (input pin_raw, output pin_sync);
endinterface

/* fbio_sync.sv */
// Two-stage synchroniser for the four external pin levels
`timescale 1ns/1ps
module fbio_sync (
  input wire logic clk,
  input wire logic rst_n,
  fbio_pin_if.pins pif
);
  logic [3:0] meta_q;
  logic [3:0] stable_q;

  // First stage feeds only the second, to contain metastability
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 4'h0;
      stable_q <= 4'h0;
    end else begin
      meta_q <= pif.pin_raw;
      stable_q <= meta_q;
    end
  end

  assign pif.pin_sync = stable_q;
endmodule

/* fbio_top.sv */
// Top: four-line bidirectional I/O port with Avalon-MM register access
//
// Design decision made here: register access over Avalon-MM.
`timescale 1ns/1ps
//------------------------------------------------------------
// How it works
// - One direction bit sets all four lines to input or output.
// - Direction bit 0 = 1 gives output, 0 gives input; it reads back.
// - Reset clears the direction bit so all lines start as inputs.
// - One pull-up bit at bit 0 governs all four pull-ups together.
// - Pull-up bit 0 enables pull-ups, 1 disables them; it is readable.
// - Reset clears the pull-up bit, leaving the lines pulled up.
// - In output mode each latched data bit drives its pin high or low.
// - Data writes are latched even while the lines are inputs.
// - In input mode a data read returns the external pin levels.
// - In output mode a data read returns the pin levels, not the latched data.
// - A read bit is 1 for a high pin and 0 for a low pin.
//------------------------------------------------------------
module fbio_top (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  output logic [31:0] AVS_READDATA,
  output logic AVS_WAITREQUEST,
  output logic [1:0] AVS_RESPONSE,
  input wire logic [3:0] PORT_LINES_IN,
  output logic [3:0] PORT_LINES_OUT,
  output logic [3:0] PORT_LINES_OE,
  output logic [3:0] PORT_PULLUP_EN
);
  fbio_pin_if pif ();

  logic [3:0] port_data_q;
  logic port_direction_select_q;
  logic pullup_disable_q;
  logic ack_q;
  logic [31:0] rdata_q;
  logic [1:0] resp_q;
  logic req;
  logic wr_take;
  logic rd_take;
  logic hit_data;
  logic hit_dir;
  logic hit_pup;
  logic [3:0] read_level;

  //------------------------------------------------------------
  // Pin input synchronisation
  //------------------------------------------------------------
  assign pif.pin_raw = PORT_LINES_IN;

  fbio_sync u_sync (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .pif(pif)
  );

  //------------------------------------------------------------
  // Bus decode
  //------------------------------------------------------------
  // One wait cycle per access: the answer is registered, waitrequest drops
  // in the second cycle of the request
  assign req = AVS_READ | AVS_WRITE;
  assign wr_take = AVS_WRITE & ~ack_q;
  assign rd_take = AVS_READ & ~ack_q;
  assign hit_data = (AVS_ADDRESS == fbio_pkg::OFF_PORT_DATA);
  assign hit_dir = (AVS_ADDRESS == fbio_pkg::OFF_PORT_DIRECTION);
  assign hit_pup = (AVS_ADDRESS == fbio_pkg::OFF_PORT_PULLUP_CONTROL);
  assign AVS_WAITREQUEST = req & ~ack_q;
  assign AVS_READDATA = rdata_q;
  assign AVS_RESPONSE = resp_q;

  // Acknowledge flag, high for exactly one cycle per request
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  //------------------------------------------------------------
  // Registers
  //------------------------------------------------------------
  // Data latch accepts writes in either direction mode
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      port_data_q <= fbio_pkg::RST_PORT_DATA;
    end else if (wr_take && hit_data && AVS_BYTEENABLE[0]) begin
      port_data_q <= AVS_WRITEDATA[3:0];
    end
  end

  // Direction bit; only bit 0 is stored, upper bits are dropped
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      port_direction_select_q <= fbio_pkg::RST_DIRECTION;
    end else if (wr_take && hit_dir && AVS_BYTEENABLE[0]) begin
      port_direction_select_q <= AVS_WRITEDATA[fbio_pkg::DIR_BIT];
    end
  end

  // Pull-up control bit; only bit 0 is stored
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      pullup_disable_q <= fbio_pkg::RST_PULLUP_DISABLE;
    end else if (wr_take && hit_pup && AVS_BYTEENABLE[0]) begin
      pullup_disable_q <= AVS_WRITEDATA[fbio_pkg::PUP_BIT];
    end
  end

  //------------------------------------------------------------
  // Pin drive
  //------------------------------------------------------------
  // One enable fans out to all four lines
  assign PORT_LINES_OE = {4{port_direction_select_q}};
  assign PORT_LINES_OUT = port_data_q;
  assign PORT_PULLUP_EN = {4{~pullup_disable_q}};

  // The pin level is read in both modes, so a heavy load that pulls a
  // driven line shows up in the read value rather than the latch
  assign read_level = pif.pin_sync;

  //------------------------------------------------------------
  // Read data
  //------------------------------------------------------------
  // Unmapped addresses read zero with a decode-error response
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'h0;
    end else if (rd_take || wr_take) begin
      rdata_q <= 32'h0000_0000;
      resp_q <= 2'h0;
      if (hit_data) begin
        rdata_q <= {28'h0000000, read_level};
      end else if (hit_dir) begin
        rdata_q <= {31'h00000000, port_direction_select_q};
      end else if (hit_pup) begin
        rdata_q <= {31'h00000000, pullup_disable_q};
      end else begin
        resp_q <= 2'h3;
      end
    end
  end
endmodule

/* fbio_pins_model.sv */
// External circuit model attached to the four port pins
`timescale 1ns/1ps
module fbio_pins_model (
  input wire logic clk,
  input wire logic [3:0] oe,
  input wire logic [3:0] out,
  input wire logic [3:0] pu,
  input wire logic [3:0] ext,
  input wire logic ext_en,
  output logic [3:0] lvl
);
  // Free lines wander every cycle so a stale value never reads as valid
  logic [3:0] flt_q = 4'h5;
  always_ff @(posedge clk) flt_q <= ~flt_q;
  // Port drive wins, then the outside source, then the pull-ups
  assign lvl = (oe & out) | (~oe & (ext_en ? ext : pu | flt_q));
endmodule

/* fbio_top_assertions.sv */
// Checker: port relations of the four-line I/O port
`timescale 1ns/1ps
module fbio_chk (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic [11:0] AVS_ADDRESS,
  input wire logic AVS_READ,
  input wire logic AVS_WRITE,
  input wire logic [31:0] AVS_WRITEDATA,
  input wire logic [3:0] AVS_BYTEENABLE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic AVS_WAITREQUEST,
  input wire logic [3:0] PORT_LINES_OUT,
  input wire logic [3:0] PORT_LINES_OE,
  input wire logic [3:0] PORT_PULLUP_EN
);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);
  // Accepted transfers; a write counts only with the low byte lane
  wire wa = AVS_WRITE && !AVS_WAITREQUEST && AVS_BYTEENABLE[0];
  wire ra = AVS_READ && !AVS_WAITREQUEST;
  chk_oe_group: assert property (
    PORT_LINES_OE inside {4'h0, 4'hf}) else $error("oe split");
  chk_pu_group: assert property (
    PORT_PULLUP_EN inside {4'h0, 4'hf}) else $error("pullup split");
  chk_dir_write: assert property (
    wa && AVS_ADDRESS == 12'hf7d |-> PORT_LINES_OE[0] == AVS_WRITEDATA[0])
    else $error("direction lost");
  chk_pu_write: assert property (
    wa && AVS_ADDRESS == 12'hf7e |-> PORT_PULLUP_EN[0] != AVS_WRITEDATA[0])
    else $error("pullup lost");
  chk_out_write: assert property (
    wa && AVS_ADDRESS == 12'hf60 |-> PORT_LINES_OUT == AVS_WRITEDATA[3:0])
    else $error("data lost");
  chk_one_wait: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("wait too long");
  chk_dir_read: assert property (
    ra && AVS_ADDRESS == 12'hf7d |-> AVS_READDATA[0] == PORT_LINES_OE[0])
    else $error("direction read");
  chk_upper_zero: assert property (
    ra && AVS_ADDRESS != 12'hf60 |-> AVS_READDATA[31:1] == 31'h0)
    else $error("upper bits");
endmodule
bind fbio_top fbio_chk chk_i (.*);

/* four_bit_io_port_bench.sv */
// Bench: register access and pin behaviour of the I/O port
`timescale 1ns/1ps
module four_bit_io_port_bench;
  logic clk, rst_n, rd, wr, ext_en, wq;
  logic [11:0] adr;
  logic [31:0] wd, rdata, r;
  logic [1:0] rsp;
  logic [3:0] pin, out, oe, pu, ext;
  int n_mismatch, cmp_count;
  // Rows: write flag, address, data byte, expected read nibble
  logic [24:0] rows [10] = '{25'h1f60050, 25'h0f6000a, 25'h1f7dff0,
    25'h0f7d001, 25'h0f60005, 25'h1f7e010, 25'h0f7e001, 25'h1f7d000,
    25'h0f6000a, 25'h0123000};
  fbio_top dut (.REF_CLK(clk), .RSTN(rst_n), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(4'hf), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wq),
    .AVS_RESPONSE(rsp), .PORT_LINES_IN(pin), .PORT_LINES_OUT(out),
    .PORT_LINES_OE(oe), .PORT_PULLUP_EN(pu));
  fbio_pins_model ext_ckt (.clk(clk), .oe(oe), .out(out), .pu(pu),
    .ext(ext), .ext_en(ext_en), .lvl(pin));
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One transfer; waitrequest is looked at mid-cycle, before the edge
  task automatic bus(input logic w, input logic [11:0] a,
    input logic [31:0] d, output logic [31:0] q);
    adr <= a;
    wd <= d;
    wr <= w;
    rd <= !w;
    do @(negedge clk); while (wq !== 1'b0);
    q = rdata;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    // Two idle cycles let pin levels pass the input synchroniser
    repeat (2) @(posedge clk);
  endtask
  task automatic end_sim;
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    end_sim();
  end
  initial begin
    {rst_n, rd, wr, adr, wd, ext, ext_en} = {1'b0, 46'h0, 4'ha, 1'b1};
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    foreach (rows[i]) begin
      bus(rows[i][24], rows[i][23:12], {24'h0, rows[i][11:4]}, r);
      if (!rows[i][24]) cmp(r, {28'h0, rows[i][3:0]});
    end
    // Source released, pull-ups on: lines must float high
    ext_en <= 1'b0;
    bus(1'b1, 12'hf7e, 32'h0, r);
    bus(1'b0, 12'hf60, 32'h0, r);
    cmp(r, 32'hf);
    bus(1'b1, 12'hf7e, 32'h1, r);
    bus(1'b1, 12'hf7d, 32'h1, r);
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    cmp({20'h0, oe, pu, out}, 32'h0f0);
    bus(1'b0, 12'hf7d, 32'h0, r);
    cmp(r, 32'h0);
    bus(1'b0, 12'hf7e, 32'h0, r);
    cmp(r, 32'h0);
    end_sim();
  end
endmodule
